// file: osdp_attr.sv
// Summary of operation
// - Toggle to colour carries shape attributes forward
// - Toggle to shape carries colour forward
// - Lone shape-kind charset select affects one character
// - First charset select of run memorised
// - Alpha serial clears, mosaic serial sets memory
// - Codes 00-1F are serial control codes
// - Colour kind: G0/G1 basic, G2/menu extended
// - Shape kind low codes: select picks G1
// - Shape kind high codes: G2/menu or ext menu
// - New colour or width overwrites second half
// - Underline ignored on upper half
// - Default colours from default colour register
// - Serial colour persists until next colour
// - Shape propagates only over colour attributes
// - Double height never propagates
// - Underline cursor lost when fg equals bg
// - Colour cursor one-based, underline zero-based
// - Scroll within window, line mode eleven rows
// - Shape byte field decode
// - Colour byte field decode
//
// The APB register port was decided locally.
`timescale 1ns/1ns
`include "osdp_cfg.svh"
module osdp_attr
   import osdp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_start,
   input  wire logic        row_start,
   input  wire logic        chr_valid,
   input  wire logic [7:0]  chr_code,
   input  wire logic [7:0]  chr_attr,
   output logic             out_valid,
   output logic [7:0]       out_code,
   output logic [2:0]       out_font,
   output logic [2:0]       out_fg,
   output logic [2:0]       out_bg,
   output logic             out_underline,
   output logic             out_separated,
   output logic             out_dbl_height,
   output logic             out_dbl_width,
   output logic             out_second_half,
   output logic             out_upper_half,
   output logic             out_box,
   output logic             out_rounding,
   output logic             out_cursor,
   output logic [3:0]       scroll_offset,
   output logic             scroll_active
);
   //----------------------------------------
   // Register bus
   //----------------------------------------
   logic [7:0] dcr_r;
   logic [7:0] curcol_r;
   logic [7:0] currow_r;
   logic [7:0] scrlo_r;
   logic [7:0] scrhi_r;
   logic [7:0] mode_r;
   logic       rdy_r;
   logic [31:0] rdat_r;
   logic       err_r;
   logic [7:0] stat_w;

   wire  [9:0] ix_w    = paddr[11:2];
   wire        setup_w = psel & ~penable;
   wire        wr_w    = psel & penable & pwrite & rdy_r;
   wire        hit_dcr = (ix_w == {2'h0, `OSDP_IX_DCR});
   wire        hit_col = (ix_w == {2'h0, `OSDP_IX_CURCOL});
   wire        hit_row = (ix_w == {2'h0, `OSDP_IX_CURROW});
   wire        hit_slo = (ix_w == {2'h0, `OSDP_IX_SCRLO});
   wire        hit_shi = (ix_w == {2'h0, `OSDP_IX_SCRHI});
   wire        hit_mod = (ix_w == {2'h0, `OSDP_IX_MODE});
   wire        hit_sta = (ix_w == {2'h0, `OSDP_IX_STAT});
   wire        ok_w    = (paddr[1:0] == 2'h0) & (hit_dcr | hit_col
                         | hit_row | hit_slo | hit_shi | hit_mod
                         | hit_sta);
   logic [7:0] rsel_w;

   always_comb
   begin
      if (hit_dcr)
         rsel_w = dcr_r;
      else if (hit_col)
         rsel_w = curcol_r;
      else if (hit_row)
         rsel_w = currow_r;
      else if (hit_slo)
         rsel_w = scrlo_r;
      else if (hit_shi)
         rsel_w = scrhi_r;
      else if (hit_mod)
         rsel_w = mode_r;
      else if (hit_sta)
         rsel_w = stat_w;
      else
         rsel_w = 8'h00;
   end

   // Answer comes in the first access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdy_r  <= 1'b0;
         rdat_r <= 32'h0;
         err_r  <= 1'b0;
      end
      else
      begin
         rdy_r  <= setup_w;
         err_r  <= setup_w & ~ok_w;
         if (setup_w)
            rdat_r <= (ok_w & ~pwrite) ? {24'h0, rsel_w} : 32'h0;
      end
   end

   // Writes to unmapped or the status word are dropped
   wire wok_w = wr_w & ~err_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dcr_r    <= `OSDP_RST_DCR;
         curcol_r <= `OSDP_RST_ZERO;
         currow_r <= `OSDP_RST_ZERO;
         scrlo_r  <= `OSDP_RST_ZERO;
         scrhi_r  <= `OSDP_RST_ZERO;
         mode_r   <= `OSDP_RST_ZERO;
      end
      else
      begin
         if (wok_w & hit_dcr)
            dcr_r <= pwdata[7:0];
         if (wok_w & hit_col)
            curcol_r <= pwdata[7:0];
         if (wok_w & hit_row)
            currow_r <= pwdata[7:0];
         if (wok_w & hit_slo)
            scrlo_r <= pwdata[7:0];
         if (wok_w & hit_shi)
            scrhi_r <= pwdata[7:0];
         if (wok_w & hit_mod)
            mode_r <= pwdata[7:0];
      end
   end

   assign prdata  = rdat_r;
   assign pready  = rdy_r;
   assign pslverr = err_r;

   //----------------------------------------
   // Attribute decode
   //----------------------------------------
   logic       prev_ps_r;
   logic       css_mem_r;
   logic       css_first_r;
   logic       mosaic_r;
   logic [2:0] fg_r;
   logic [2:0] bg_r;
   logic [3:0] shp_r;
   logic       prop_r;
   logic       dw_pend_r;
   logic [7:0] dw_code_r;
   logic [2:0] dw_font_r;
   logic [7:0] col_r;
   logic [7:0] row_r;

   wire ps_w     = chr_attr[`OSDP_B_PS];
   wire ctrl_w   = (chr_code[7:5] == 3'h0);
   wire hi_w     = chr_code[7];
   // Serial colour: 00-07 alpha, 10-17 mosaic
   wire scol_w   = ctrl_w & ~chr_code[`OSDP_B_SNOCOL];
   wire salpha_w = scol_w & ~chr_code[`OSDP_B_SMOS];
   wire smos_w   = scol_w & chr_code[`OSDP_B_SMOS];
   wire run_w    = ps_w & ~prev_ps_r;
   wire mos_w    = smos_w | (mosaic_r & ~salpha_w);

   // Shape-kind select: only its own character unless a run follows
   wire css_w    = ps_w ? chr_attr[`OSDP_B_CSS] : css_mem_r;
   // Order: {rounding, box, double height, underline}
   wire [3:0] shp_a_w = {chr_attr[`OSDP_B_SR], chr_attr[`OSDP_B_BX],
                         chr_attr[`OSDP_B_DH], chr_attr[`OSDP_B_US]};
   wire prop_w   = ~ps_w & (prev_ps_r | prop_r);
   // Carried shape never includes double height
   wire [3:0] shp_w = ps_w ? shp_a_w
                    : prop_w ? (shp_r & 4'b1101)
                    : 4'h0;
   wire dh_w     = ps_w & chr_attr[`OSDP_B_DH];
   wire dw_w     = ps_w & chr_attr[`OSDP_B_DW];
   wire uh_w     = ps_w & chr_attr[`OSDP_B_UH];
   // Colour: parallel colour byte, else serial (foreground only), else held
   wire [2:0] fg_w = ~ps_w ? chr_attr[`OSDP_F_FG]
                   : scol_w ? chr_code[`OSDP_F_SCOL]
                   : fg_r;
   wire [2:0] bg_w = ~ps_w ? chr_attr[`OSDP_F_BG] : bg_r;
   wire newcol_w = ~ps_w | scol_w;

   // Next location overwrites a widened character on new colour or
   // another double width, otherwise shows its second half
   wire ovr_w    = newcol_w | dw_w;
   wire half_w   = dw_pend_r & ~ovr_w;

   osdp_font_e font_w;
   always_comb
   begin
      if (ctrl_w)
         font_w = OSDP_FONT_CTRL;
      else if (hi_w & ps_w & css_w)
         font_w = OSDP_FONT_XM;
      else if (hi_w)
         font_w = OSDP_FONT_G2M;
      else if (css_w | mos_w)
         font_w = OSDP_FONT_G1;
      else
         font_w = OSDP_FONT_G0;
   end

   // Underline only on single height or lower half
   wire ul_w = shp_w[0] & ~(dh_w & uh_w);

   //----------------------------------------
   // Cursor
   //----------------------------------------
   osdp_cur_e cmode_w;
   logic [7:0] frame_cnt_r;
   assign cmode_w = osdp_cur_e'(mode_r[`OSDP_F_CURMODE]);
   wire row_hit_w = (row_r == currow_r);
   wire [7:0] col1_w = 8'(col_r + 8'h1);
   wire col_c_w   = (col1_w == curcol_r);
   wire col_u_w   = (col_r == curcol_r);
   wire flash_w   = frame_cnt_r[`OSDP_FLASH_BIT];
   logic cur_w;
   always_comb
   begin
      case (cmode_w)
         OSDP_CUR_STAT:  cur_w = row_hit_w & col_c_w;
         OSDP_CUR_FLASH: cur_w = row_hit_w & col_c_w & flash_w;
         OSDP_CUR_UL:    cur_w = row_hit_w & col_u_w
                                 & (fg_w != bg_w);
         default:        cur_w = 1'b0;
      endcase
   end

   //----------------------------------------
   // Row state
   //----------------------------------------
   wire [2:0] dfg_w = dcr_r[`OSDP_F_DFG];
   wire [2:0] dbg_w = dcr_r[`OSDP_F_DBG];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_ps_r   <= 1'b0;
         css_mem_r   <= 1'b0;
         css_first_r <= 1'b0;
         mosaic_r    <= 1'b0;
         fg_r        <= 3'h0;
         bg_r        <= 3'h0;
         shp_r       <= 4'h0;
         prop_r      <= 1'b0;
         dw_pend_r   <= 1'b0;
         dw_code_r   <= 8'h0;
         dw_font_r   <= 3'h0;
      end
      else if (row_start)
      begin
         // Every row opens in the default colours
         prev_ps_r   <= 1'b0;
         css_mem_r   <= 1'b0;
         css_first_r <= 1'b0;
         mosaic_r    <= 1'b0;
         fg_r        <= dfg_w;
         bg_r        <= dbg_w;
         shp_r       <= 4'h0;
         prop_r      <= 1'b0;
         dw_pend_r   <= 1'b0;
      end
      else if (chr_valid)
      begin
         prev_ps_r <= ps_w;
         fg_r      <= fg_w;
         bg_r      <= bg_w;
         mosaic_r  <= mos_w;
         prop_r    <= prop_w;
         if (ps_w)
            shp_r <= shp_a_w;
         if (run_w)
            css_first_r <= chr_attr[`OSDP_B_CSS];
         // Serial colours force the memory, run copy comes last
         if (salpha_w)
            css_mem_r <= 1'b0;
         else if (smos_w)
            css_mem_r <= 1'b1;
         else if (ps_w & prev_ps_r)
            css_mem_r <= css_first_r;
         dw_pend_r <= dw_w;
         if (dw_w)
         begin
            dw_code_r <= chr_code;
            dw_font_r <= font_w;
         end
      end
   end

   //----------------------------------------
   // Position counters
   //----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         col_r       <= 8'h0;
         row_r       <= 8'h0;
         frame_cnt_r <= 8'h0;
      end
      else if (frame_start)
      begin
         col_r       <= 8'h0;
         row_r       <= 8'h0;
         frame_cnt_r <= 8'(frame_cnt_r + 8'h1);
      end
      else if (row_start)
      begin
         col_r <= 8'h0;
         row_r <= 8'(row_r + 8'h1);
      end
      else if (chr_valid)
         col_r <= 8'(col_r + 8'h1);
   end

   //----------------------------------------
   // Vertical scrolling
   //----------------------------------------
   logic [3:0] soff_r;
   logic [2:0] sdiv_r;
   logic       sact_r;
   logic       dh_seen_r;
   wire [4:0] wtop_w = {1'b0, scrhi_r[`OSDP_F_WTOP]};
   wire [4:0] wbot_w = {1'b0, scrhi_r[`OSDP_F_WBOT]};
   wire [4:0] wraw_w = 5'(wbot_w - wtop_w);
   // Line mode only has eleven programmed rows to scroll over
   wire [4:0] wlen_w = (mode_r[`OSDP_B_LINEMODE]
                        & (wraw_w > `OSDP_LINE_ROWS))
                       ? `OSDP_LINE_ROWS : wraw_w;
   wire [3:0] wmax_w = (wlen_w == 5'h0) ? 4'h0
                       : 4'(wlen_w - 5'h1);
   // Double height inside the window holds the roll
   wire s_on_w  = scrlo_r[`OSDP_B_SCR_EN] & (wbot_w > wtop_w)
                  & ~dh_seen_r;
   wire s_step_w = frame_start & s_on_w
                   & ~scrlo_r[`OSDP_B_SCR_FRZ]
                   & (sdiv_r == scrlo_r[`OSDP_F_SCR_SPD]);
   wire in_win_w = ({4'h0, row_r} >= {4'h0, wtop_w})
                   & ({4'h0, row_r} < {4'h0, wbot_w});

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         soff_r    <= 4'h0;
         sdiv_r    <= 3'h0;
         sact_r    <= 1'b0;
         dh_seen_r <= 1'b0;
      end
      else
      begin
         sact_r <= s_on_w;
         if (frame_start)
            sdiv_r <= (sdiv_r == scrlo_r[`OSDP_F_SCR_SPD])
                      ? 3'h0 : 3'(sdiv_r + 3'h1);
         if (!s_on_w & ~dh_seen_r)
            soff_r <= 4'h0;
         else if (s_step_w & ~scrlo_r[`OSDP_B_SCR_DN])
            soff_r <= (soff_r >= wmax_w) ? 4'h0 : 4'(soff_r + 4'h1);
         else if (s_step_w)
            soff_r <= (soff_r == 4'h0) ? wmax_w : 4'(soff_r - 4'h1);
         if (frame_start)
            dh_seen_r <= 1'b0;
         else if (chr_valid & dh_w & in_win_w)
            dh_seen_r <= 1'b1;
      end
   end

   assign scroll_offset = soff_r;
   assign scroll_active = sact_r;
   assign stat_w = {mosaic_r, css_mem_r, sact_r, dh_seen_r, soff_r};

   //----------------------------------------
   // Output stage
   //----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_valid       <= 1'b0;
         out_code        <= 8'h0;
         out_font        <= 3'h0;
         out_fg          <= 3'h0;
         out_bg          <= 3'h0;
         out_underline   <= 1'b0;
         out_separated   <= 1'b0;
         out_dbl_height  <= 1'b0;
         out_dbl_width   <= 1'b0;
         out_second_half <= 1'b0;
         out_upper_half  <= 1'b0;
         out_box         <= 1'b0;
         out_rounding    <= 1'b0;
         out_cursor      <= 1'b0;
      end
      else
      begin
         out_valid <= chr_valid & ~row_start;
         if (chr_valid & ~row_start)
         begin
            out_code        <= half_w ? dw_code_r : chr_code;
            out_font        <= half_w ? dw_font_r : font_w;
            out_fg          <= fg_w;
            out_bg          <= bg_w;
            // Same bit underlines text, separates mosaics
            out_underline   <= ul_w & ~mos_w;
            out_separated   <= shp_w[0] & mos_w;
            out_dbl_height  <= dh_w;
            out_dbl_width   <= dw_w | half_w;
            out_second_half <= half_w;
            out_upper_half  <= uh_w & dh_w;
            out_box         <= shp_w[2];
            out_rounding    <= shp_w[3];
            out_cursor      <= cur_w;
         end
      end
   end
endmodule

// file: osdp_cfg.svh
`ifndef OSDP_CFG_SVH
`define OSDP_CFG_SVH
// Register indexes, byte address is four times the index
`define OSDP_IX_DCR      8'hf0
`define OSDP_IX_CURCOL   8'hf6
`define OSDP_IX_CURROW   8'hf7
`define OSDP_IX_SCRLO    8'hf8
`define OSDP_IX_SCRHI    8'hf9
`define OSDP_IX_MODE     8'hfa
`define OSDP_IX_STAT     8'hfb
// Reset values
`define OSDP_RST_DCR     8'h07
`define OSDP_RST_ZERO    8'h00
// Attribute byte fields
`define OSDP_B_PS        7
`define OSDP_B_CSS       0
`define OSDP_B_US        1
`define OSDP_B_DH        2
`define OSDP_B_DW        3
`define OSDP_B_UH        4
`define OSDP_B_BX        5
`define OSDP_B_SR        6
`define OSDP_F_FG        6:4
`define OSDP_F_BG        2:0
// Default colour register fields
`define OSDP_F_DFG       2:0
`define OSDP_F_DBG       6:4
// Serial colour codes: 0x00-0x07 alpha, 0x10-0x17 mosaic
`define OSDP_F_SCOL      2:0
`define OSDP_B_SMOS      4
`define OSDP_B_SNOCOL    3
// Mode register fields
`define OSDP_F_CURMODE   1:0
`define OSDP_B_LINEMODE  2
// Scroll control fields
`define OSDP_B_SCR_EN    0
`define OSDP_B_SCR_DN    1
`define OSDP_B_SCR_FRZ   2
`define OSDP_F_SCR_SPD   5:3
`define OSDP_F_WTOP      3:0
`define OSDP_F_WBOT      7:4
// Line mode holds at most this many programmed rows
`define OSDP_LINE_ROWS   5'd11
`define OSDP_FLASH_BIT   4
`endif

// file: osdp_pkg.sv
package osdp_pkg;
   typedef enum logic [2:0]
   {
      OSDP_FONT_CTRL = 3'b000,
      OSDP_FONT_G0   = 3'b001,
      OSDP_FONT_G1   = 3'b010,
      OSDP_FONT_G2M  = 3'b011,
      OSDP_FONT_XM   = 3'b100
   } osdp_font_e;
   typedef enum logic [1:0]
   {
      OSDP_CUR_OFF   = 2'b00,
      OSDP_CUR_STAT  = 2'b01,
      OSDP_CUR_FLASH = 2'b10,
      OSDP_CUR_UL    = 2'b11
   } osdp_cur_e;
endpackage

// file: osdp_attr_assertions.sv
`timescale 1ns/1ns
module osdp_attr_assertions
   import osdp_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        row_start,
   input wire logic        chr_valid,
   input wire logic [7:0]  chr_code,
   input wire logic [7:0]  chr_attr,
   input wire logic        out_valid,
   input wire logic [2:0]  out_font,
   input wire logic [2:0]  out_fg,
   input wire logic [2:0]  out_bg,
   input wire logic        out_underline,
   input wire logic        out_dbl_height,
   input wire logic        out_dbl_width,
   input wire logic        out_second_half,
   input wire logic        out_box
);
   // ------------------
   // Steps of transfers
   // ------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_take;
      chr_valid && !row_start;
   endsequence
   // Double width start keeps a pending second half from hiding the decode
   sequence s_dw_shape;
      s_take ##0 chr_attr[7] && chr_attr[3] && chr_code >= 8'h20;
   endsequence
   // ----------
   // Properties
   // ----------
   a_ready_next: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_bad_align: assert property (s_setup ##0 paddr[1:0] != 2'h0
      |=> pslverr && prdata == 32'h0)
      else $error("misaligned access not refused");
   a_chr_answer: assert property (s_take |=> out_valid)
      else $error("character not answered");
   a_no_stray: assert property (out_valid |-> $past(chr_valid && !row_start))
      else $error("out_valid without a character");
   a_ctrl_font: assert property (
      s_take ##0 chr_code < 8'h20 && !chr_attr[7]
      |=> out_font == OSDP_FONT_CTRL) else $error("control code font wrong");
   a_css_g1: assert property (
      s_dw_shape ##0 chr_attr[0] && !chr_code[7]
      |=> out_font == OSDP_FONT_G1) else $error("charset select not G1");
   a_high_font: assert property (s_dw_shape ##0 chr_code[7]
      |=> out_font == ($past(chr_attr[0]) ? OSDP_FONT_XM : OSDP_FONT_G2M))
      else $error("extended font wrong");
   a_upper_ul: assert property (
      s_dw_shape ##0 chr_attr[2] && chr_attr[4] |=> !out_underline)
      else $error("underline on upper half");
   a_dw_fresh: assert property (s_dw_shape |=> out_dbl_width
      && !out_second_half && out_box == $past(chr_attr[5]))
      else $error("double width decode wrong");
   a_colour_take: assert property (
      s_take ##0 !chr_attr[7] && chr_code >= 8'h20
      |=> out_fg == $past(chr_attr[6:4]) && out_bg == $past(chr_attr[2:0])
      && !out_dbl_height) else $error("colour byte decode wrong");
endmodule

bind osdp_attr osdp_attr_assertions u_chk (.pclk, .presetn, .psel, .penable,
   .paddr, .prdata, .pready, .pslverr, .row_start, .chr_valid, .chr_code,
   .chr_attr, .out_valid, .out_font, .out_fg, .out_bg, .out_underline,
   .out_dbl_height, .out_dbl_width, .out_second_half, .out_box);

// file: testbench.sv
`timescale 1ns/1ns
`include "osdp_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module testbench
   import osdp_pkg::*;
;
   logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
   logic        frame_start = '0, row_start = '0, chr_valid = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0]  chr_code = '0, chr_attr = '0, out_code;
   logic [2:0]  out_font, out_fg, out_bg;
   logic        pready, pslverr, er, out_valid, out_underline, out_separated;
   logic        out_dbl_height, out_dbl_width, out_second_half, out_upper_half;
   logic        out_box, out_rounding, out_cursor, scroll_active;
   logic [3:0]  scroll_offset;
   int          failures = 0, checked = 0, i;
   logic [7:0]  rix [5] = '{8'hf0, 8'hf6, 8'hf7, 8'hf8, 8'hf9};
   // Code, attribute, font, fg, bg; default colours are fg 5, bg 2 here
   logic [24:0] rows [8] = '{
      {8'h41, 8'h36, OSDP_FONT_G0, 3'h3, 3'h6},
      {8'hc1, 8'h70, OSDP_FONT_G2M, 3'h7, 3'h0},
      {8'h41, 8'h89, OSDP_FONT_G1, 3'h5, 3'h2},
      {8'h41, 8'h88, OSDP_FONT_G0, 3'h5, 3'h2},
      {8'hc1, 8'h88, OSDP_FONT_G2M, 3'h5, 3'h2},
      {8'hc1, 8'h89, OSDP_FONT_XM, 3'h5, 3'h2},
      {8'h05, 8'h52, OSDP_FONT_CTRL, 3'h5, 3'h2},
      {8'h1a, 8'h80, OSDP_FONT_CTRL, 3'h5, 3'h2}};

   osdp_attr uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .frame_start, .row_start, .chr_valid,
      .chr_code, .chr_attr, .out_valid, .out_code, .out_font, .out_fg,
      .out_bg, .out_underline, .out_separated, .out_dbl_height,
      .out_dbl_width, .out_second_half, .out_upper_half, .out_box,
      .out_rounding, .out_cursor, .scroll_offset, .scroll_active);

   always #50 pclk = ~pclk;

   // -----------
   // Bus drivers
   // -----------
   task automatic apb(input logic w, input logic [7:0] ix,
      input logic [1:0] lo, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= {2'h0, ix, lo};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) failures++;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic chr(input logic [7:0] c, input logic [7:0] a);
      chr_valid <= 1'h1;
      chr_code <= c;
      chr_attr <= a;
      @(posedge pclk);
      chr_valid <= 1'h0;
      #1;
      `CHK(out_valid, 1'h1)
      @(posedge pclk);
   endtask

   task automatic fc(input logic [7:0] c, input logic [7:0] a,
      input logic [2:0] f);
      chr(c, a);
      `CHK(out_font, f)
   endtask

   task automatic new_row(input logic f);
      frame_start <= f;
      @(posedge pclk);
      frame_start <= 1'h0;
      row_start <= 1'h1;
      @(posedge pclk);
      row_start <= 1'h0;
   endtask

   task complete_run;
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #500000;
      failures++;
      complete_run();
   end

   // -----
   // Tests
   // -----
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      for (i = 0; i < 5; i++)
      begin
         apb(1'h0, rix[i], 2'h0, 32'h0);
         `CHK(rd, (i == 0) ? 32'h07 : 32'h0)
         apb(1'h1, rix[i], 2'h0, 32'h33);
         apb(1'h0, rix[i], 2'h0, 32'h0);
         `CHK(rd, 32'h33)
      end
      apb(1'h1, `OSDP_IX_SCRLO, 2'h0, 32'h0);
      apb(1'h1, `OSDP_IX_DCR, 2'h0, 32'h25);
      apb(1'h0, 8'h01, 2'h0, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      apb(1'h1, `OSDP_IX_CURCOL, 2'h1, 32'hff);
      `CHK(er, 1'h1)
      apb(1'h0, `OSDP_IX_CURCOL, 2'h0, 32'h0);
      `CHK(rd, 32'h33)
      for (i = 0; i < 8; i++)
      begin
         new_row(1'h0);
         fc(rows[i][24:17], rows[i][16:9], rows[i][8:6]);
         `CHK({out_fg, out_bg}, rows[i][5:0])
      end
      // Charset memory over runs and serial colour codes
      new_row(1'h0);
      fc(8'h41, 8'h81, OSDP_FONT_G1);
      fc(8'h41, 8'h80, OSDP_FONT_G0);
      fc(8'h41, 8'h52, OSDP_FONT_G1);
      fc(8'h41, 8'h80, OSDP_FONT_G0);
      fc(8'h41, 8'h81, OSDP_FONT_G1);
      fc(8'h41, 8'h52, OSDP_FONT_G0);
      fc(8'h10, 8'h80, OSDP_FONT_CTRL);
      fc(8'h41, 8'h52, OSDP_FONT_G1);
      fc(8'h03, 8'h80, OSDP_FONT_CTRL);
      fc(8'h41, 8'h80, OSDP_FONT_G0);
      `CHK(out_fg, 3'h3)
      // Shape carried over colour bytes, double height never
      new_row(1'h0);
      chr(8'h41, 8'ha4);
      chr(8'h41, 8'h52);
      `CHK({out_box, out_dbl_height}, 2'h2)
      chr(8'h41, 8'h52);
      `CHK(out_box, 1'h1)
      chr(8'h41, 8'h80);
      `CHK({out_box, out_fg}, 4'h5)
      chr(8'h41, 8'h52);
      `CHK(out_box, 1'h0)
      // Double width second half and overwrite
      new_row(1'h0);
      chr(8'h41, 8'h88);
      chr(8'h42, 8'h80);
      `CHK({out_code, out_second_half, out_dbl_width}, 10'h107)
      chr(8'h43, 8'h88);
      chr(8'h44, 8'h88);
      `CHK({out_code, out_second_half}, 9'h088)
      // Underline only on single height or the lower half
      new_row(1'h0);
      chr(8'h41, 8'h82);
      `CHK(out_underline, 1'h1)
      chr(8'h41, 8'h9e);
      `CHK(out_underline, 1'h0)
      chr(8'h41, 8'h96);
      `CHK(out_underline, 1'h0)
      new_row(1'h0);
      chr(8'h41, 8'h8e);
      `CHK({out_underline, out_dbl_height}, 2'h3)
      chr(8'h41, 8'h86);
      `CHK({out_underline, out_dbl_height}, 2'h3)
      // Cursor column conventions
      apb(1'h1, `OSDP_IX_MODE, 2'h0, 32'h1);
      apb(1'h1, `OSDP_IX_CURCOL, 2'h0, 32'h2);
      // First row after a frame start is row one
      apb(1'h1, `OSDP_IX_CURROW, 2'h0, 32'h1);
      new_row(1'h1);
      for (i = 0; i < 3; i++)
      begin
         chr(8'h41, 8'h52);
         `CHK(out_cursor, (i == 1))
      end
      apb(1'h1, `OSDP_IX_MODE, 2'h0, 32'h3);
      apb(1'h1, `OSDP_IX_CURCOL, 2'h0, 32'h1);
      for (i = 0; i < 2; i++)
      begin
         new_row(1'h1);
         chr(8'h41, 8'h52);
         `CHK(out_cursor, 1'h0)
         chr(8'h41, (i == 0) ? 8'h52 : 8'h22);
         `CHK(out_cursor, (i == 0))
      end
      // Roll through a line-mode window clamped to eleven rows
      apb(1'h1, `OSDP_IX_MODE, 2'h0, 32'h4);
      apb(1'h1, `OSDP_IX_SCRHI, 2'h0, 32'hf0);
      apb(1'h1, `OSDP_IX_SCRLO, 2'h0, 32'h1);
      @(posedge pclk);
      `CHK({scroll_active, scroll_offset}, 5'h10)
      for (i = 0; i < 11; i++)
      begin
         new_row(1'h1);
         `CHK(scroll_offset, (i == 10) ? 4'h0 : 4'(i + 1))
      end
      // Double height inside the window holds the roll
      chr(8'h41, 8'h84);
      apb(1'h0, `OSDP_IX_STAT, 2'h0, 32'h0);
      `CHK(rd, 32'h10)
      // Flash phase follows frame count bit 4; 14 frames so far
      apb(1'h1, `OSDP_IX_MODE, 2'h0, 32'h2);
      apb(1'h1, `OSDP_IX_CURCOL, 2'h0, 32'h1);
      for (i = 0; i < 3; i++)
      begin
         new_row(1'h1);
         chr(8'h41, 8'h52);
         `CHK(out_cursor, (i != 0))
      end
      complete_run();
   end
endmodule
